//--- logic/jtfa_frame_assembler.sv
`timescale 1ns/1ns
`default_nettype none
module jtfa_frame_assembler #(
  parameter int ADDR_W = 8
) (
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire logic                 ce,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [ADDR_W-1:0]    paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 frm_valid,
  output logic                      frm_ready,
  input  wire jtfa_pkg::jtfa_chan_s chan_a_in,
  input  wire jtfa_pkg::jtfa_chan_s chan_b_in,
  output logic      [7:0]           chan_a_lane_0,
  output logic      [7:0]           chan_a_lane_1,
  output logic      [7:0]           chan_a_lane_2,
  output logic      [7:0]           chan_a_lane_3,
  output logic      [7:0]           chan_b_lane_0,
  output logic      [7:0]           chan_b_lane_1,
  output logic      [7:0]           chan_b_lane_2,
  output logic      [7:0]           chan_b_lane_3,
  output logic                      lane_valid,
  output logic                      frame_start,
  output logic      [3:0]           lane_active,
  output logic      [1:0]           format_select_0,
  output logic      [1:0]           format_select_1,
  output logic      [1:0]           format_select_2
);

  localparam int LW = jtfa_pkg::LANE_W;
  localparam int OW = jtfa_pkg::OCT_W;
  localparam int CW = jtfa_pkg::CPX_W;
  localparam int HB = CW / 2;

  typedef logic [jtfa_pkg::LANES-1:0][LW-1:0] jtfa_lanes_t;

  // ----------------------------------------------------------------
  // Lane word builder, octets left aligned
  // ----------------------------------------------------------------
  function automatic jtfa_lanes_t jtfa_build(input jtfa_pkg::jtfa_fmt_e fmt,
                                             input jtfa_pkg::jtfa_chan_s ch);
    jtfa_lanes_t w;
    logic [jtfa_pkg::B12_PER*jtfa_pkg::B12_W-1:0] pk;
    w  = '0;
    pk = '0;
    unique case (fmt)
      jtfa_pkg::FMT_B12: begin
        for (int k = 0; k < jtfa_pkg::LANES; k++) begin
          for (int j = 0; j < jtfa_pkg::B12_PER; j++) begin
            pk[(jtfa_pkg::B12_PER-j)*jtfa_pkg::B12_W-1 -: jtfa_pkg::B12_W] =
              ch.raw[jtfa_pkg::B12_PER*k+j][jtfa_pkg::RAW_W-1:jtfa_pkg::B12_DROP];
          end
          w[k] = {pk, {jtfa_pkg::B12_TAIL{1'b0}}};
        end
      end
      jtfa_pkg::FMT_B14: begin
        for (int k = 0; k < jtfa_pkg::LANES; k++) begin
          w[k][LW-1 -: jtfa_pkg::RAW_W+jtfa_pkg::B14_PAD] =
            {ch.raw[k], {jtfa_pkg::B14_PAD{1'b0}}};
        end
      end
      jtfa_pkg::FMT_8411: begin
        w[0][LW-1 -: OW] = ch.ci[0][CW-1:HB];
        w[1][LW-1 -: OW] = ch.ci[0][HB-1:0];
        w[2][LW-1 -: OW] = ch.cq[0][CW-1:HB];
        w[3][LW-1 -: OW] = ch.cq[0][HB-1:0];
      end
      jtfa_pkg::FMT_8422: begin
        w[0][LW-1 -: CW] = ch.ci[0];
        w[1][LW-1 -: CW] = ch.ci[1];
        w[2][LW-1 -: CW] = ch.cq[0];
        w[3][LW-1 -: CW] = ch.cq[1];
      end
      jtfa_pkg::FMT_4421L: begin
        w[0][LW-1 -: CW] = ch.ci[0];
        w[1][LW-1 -: CW] = ch.cq[0];
      end
      jtfa_pkg::FMT_4421H: begin
        w[1][LW-1 -: CW] = ch.ci[0];
        w[2][LW-1 -: CW] = ch.cq[0];
      end
      jtfa_pkg::FMT_4442: begin
        w[1][LW-1 -: 2*CW] = {ch.ci[0], ch.ci[1]};
        w[2][LW-1 -: 2*CW] = {ch.cq[0], ch.cq[1]};
      end
      jtfa_pkg::FMT_2441: begin
        w[1][LW-1 -: 2*CW] = {ch.ci[0], ch.cq[0]};
      end
    endcase
    return w;
  endfunction : jtfa_build

  function automatic jtfa_lanes_t jtfa_shift(input jtfa_lanes_t b);
    jtfa_lanes_t w;
    w = '0;
    for (int k = 0; k < jtfa_pkg::LANES; k++) begin
      w[k] = {b[k][LW-OW-1:0], {OW{1'b0}}};
    end
    return w;
  endfunction : jtfa_shift

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic [31:0]                      ctrl_r;
  logic [31:0]                      prdata_r;
  logic                             rd_ok_r;
  jtfa_lanes_t                      buf_a_r;
  jtfa_lanes_t                      buf_b_r;
  logic [jtfa_pkg::CNT_W-1:0]       cnt_r;
  logic                             busy_r;
  logic                             start_r;
  logic [3:0]                       mask_r;
  logic [1:0]                       fs0_r;
  logic [1:0]                       fs1_r;
  logic [1:0]                       fs2_r;
  logic [3:0]                       act_f_r;

  // ----------------------------------------------------------------
  // Configuration decode
  // ----------------------------------------------------------------
  wire logic                  cfg_en     = ctrl_r[jtfa_pkg::CTRL_EN];
  wire logic [3:0]            cfg_dec    = ctrl_r[jtfa_pkg::CTRL_DEC +: 4];
  wire jtfa_pkg::jtfa_fmt_e   cfg_fmt    = jtfa_pkg::jtfa_fmt_e'(ctrl_r[jtfa_pkg::CTRL_FMT +: 3]);
  wire jtfa_pkg::jtfa_info_s  cfg_info   = jtfa_pkg::FMT_TAB[cfg_fmt];
  wire logic [7:0]            legal_set  = jtfa_pkg::DEC_LEGAL[cfg_dec];
  wire logic                  cfg_legal  = legal_set[cfg_fmt];
  wire logic                  ratio_hi   = (cfg_info.pll == jtfa_pkg::PLL_40X) ||
                                           (cfg_fmt == jtfa_pkg::FMT_B14);
  wire logic [9:0]            cfg_ratio  = ratio_hi ? jtfa_pkg::RATIO_HI[cfg_dec]
                                                    : jtfa_pkg::RATIO_LO[cfg_dec];
  wire logic                  run        = cfg_en & cfg_legal;

  // ----------------------------------------------------------------
  // Frame capture and octet sequencing
  // ----------------------------------------------------------------
  wire logic [jtfa_pkg::CNT_W-1:0] last_cnt = jtfa_pkg::CNT_W'(act_f_r - 4'h1);
  wire logic        last_oct = busy_r & (cnt_r == last_cnt);
  wire logic        take     = ce & frm_valid & frm_ready;
  wire jtfa_lanes_t lanes_a  = jtfa_build(cfg_fmt, chan_a_in);
  wire jtfa_lanes_t lanes_b  = jtfa_build(cfg_fmt, chan_b_in);
  wire jtfa_lanes_t shift_a  = jtfa_shift(buf_a_r);
  wire jtfa_lanes_t shift_b  = jtfa_shift(buf_b_r);
  wire jtfa_lanes_t buf_a_nxt = take ? lanes_a : (busy_r ? shift_a : buf_a_r);
  wire jtfa_lanes_t buf_b_nxt = take ? lanes_b : (busy_r ? shift_b : buf_b_r);
  wire logic        busy_nxt  = take | (busy_r & ~last_oct);
  wire logic [jtfa_pkg::CNT_W-1:0] cnt_nxt = take ? '0 : cnt_r + 1'b1;

  assign frm_ready = ce & run & (~busy_r | last_oct);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      buf_a_r <= '0;
      buf_b_r <= '0;
      cnt_r   <= '0;
      busy_r  <= 1'b0;
      start_r <= 1'b0;
    end else if (ce) begin
      buf_a_r <= buf_a_nxt;
      buf_b_r <= buf_b_nxt;
      cnt_r   <= cnt_nxt;
      busy_r  <= busy_nxt;
      start_r <= take;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mask_r  <= 4'h0;
      fs0_r   <= 2'h0;
      fs1_r   <= 2'h0;
      fs2_r   <= 2'h0;
      act_f_r <= 4'h1;
    end else if (take) begin
      mask_r  <= cfg_info.mask;
      fs0_r   <= cfg_info.c0;
      fs1_r   <= cfg_info.c1;
      fs2_r   <= cfg_info.c2;
      act_f_r <= cfg_info.f;
    end
  end

  assign chan_a_lane_0   = buf_a_r[0][LW-1 -: OW];
  assign chan_a_lane_1   = buf_a_r[1][LW-1 -: OW];
  assign chan_a_lane_2   = buf_a_r[2][LW-1 -: OW];
  assign chan_a_lane_3   = buf_a_r[3][LW-1 -: OW];
  assign chan_b_lane_0   = buf_b_r[0][LW-1 -: OW];
  assign chan_b_lane_1   = buf_b_r[1][LW-1 -: OW];
  assign chan_b_lane_2   = buf_b_r[2][LW-1 -: OW];
  assign chan_b_lane_3   = buf_b_r[3][LW-1 -: OW];
  assign lane_valid      = busy_r;
  assign frame_start     = start_r;
  assign lane_active     = busy_r ? mask_r : 4'h0;
  assign format_select_0 = fs0_r;
  assign format_select_1 = fs1_r;
  assign format_select_2 = fs2_r;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  wire logic [7:0]  addr_w   = 8'(paddr);
  wire logic        hit_ctrl = (addr_w == jtfa_pkg::ADDR_CTRL);
  wire logic        hit_stat = (addr_w == jtfa_pkg::ADDR_STATUS);
  wire logic        hit_link = (addr_w == jtfa_pkg::ADDR_LINK);
  wire logic        unmapped = ~(hit_ctrl | hit_stat | hit_link);
  wire logic        done     = psel & penable & pready;
  wire logic        wr_ctrl  = done & pwrite & hit_ctrl;

  wire logic [31:0] stat_word =
    (32'(cfg_legal) << jtfa_pkg::ST_LEGAL) |
    (32'(busy_r)    << jtfa_pkg::ST_BUSY) |
    (32'(cfg_info.l) << jtfa_pkg::ST_L) |
    (32'(cfg_info.m) << jtfa_pkg::ST_M) |
    (32'(cfg_info.f) << jtfa_pkg::ST_F) |
    (32'(cfg_info.s) << jtfa_pkg::ST_S);
  wire logic [31:0] link_word =
    (32'(cfg_ratio)    << jtfa_pkg::LK_RATIO) |
    (32'(cfg_info.pll) << jtfa_pkg::LK_PLL) |
    (32'(cfg_info.c0)  << jtfa_pkg::LK_C0) |
    (32'(cfg_info.c1)  << jtfa_pkg::LK_C1) |
    (32'(cfg_info.c2)  << jtfa_pkg::LK_C2);
  wire logic [31:0] rd_mux = hit_ctrl ? ctrl_r :
                             hit_stat ? stat_word :
                             hit_link ? link_word : 32'h0000_0000;

  assign pready  = ce & rd_ok_r;
  assign pslverr = pready & unmapped;
  assign prdata  = prdata_r;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_r   <= jtfa_pkg::CTRL_RST;
      prdata_r <= 32'h0000_0000;
      rd_ok_r  <= 1'b0;
    end else if (ce) begin
      rd_ok_r  <= psel & ~done;
      prdata_r <= (psel & ~rd_ok_r) ? rd_mux : prdata_r;
      ctrl_r   <= wr_ctrl ? pwdata : ctrl_r;
    end
  end

endmodule : jtfa_frame_assembler
`default_nettype wire

//--- logic/jtfa_pkg.sv
// Contract
// - 14-bit sample: high eight bits, then low six plus 00
// - 14-bit: sample n on lane n
// - Channel B assembled alike on own lanes
// - 12-bit: five samples per lane, eight octets
// - 12-bit samples packed back to back, MSB first
// - 12-bit lane ends with four zero tail bits
// - Decimate-by-4 supports 8411, 8422, 4421, 4442 formats
// - Decimate-by-4 format-select codes per format
// - Lane rate ratios for decimate by 4 and 6
// - Decimate 8 to 20: only 4421 and 2441
// - Lane rate ratios for decimate 8 to 20
// - Decimate 24: 4421 only; 32: 2441 only
// - 12-bit output drops two sample LSBs
// - F octets, L lanes, M converters, S samples
package jtfa_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int OCT_W     = 8;
  localparam int LANE_W    = 64;
  localparam int LANES     = 4;
  localparam int RAW_N     = 20;
  localparam int RAW_W     = 14;
  localparam int CPX_N     = 2;
  localparam int CPX_W     = 16;
  localparam int B12_W     = 12;
  localparam int B12_DROP  = 2;
  localparam int B12_PER   = 5;
  localparam int B12_TAIL  = 4;
  localparam int B14_PAD   = 2;
  localparam int CNT_W     = 3;

  // ----------------------------------------------------------------
  // Formats and decimation settings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FMT_B12    = 3'h0,
    FMT_B14    = 3'h1,
    FMT_8411   = 3'h2,
    FMT_8422   = 3'h3,
    FMT_4421L  = 3'h4,
    FMT_4421H  = 3'h5,
    FMT_4442   = 3'h6,
    FMT_2441   = 3'h7
  } jtfa_fmt_e;

  typedef enum logic [3:0] {
    DEC_BYP = 4'h0, DEC_4  = 4'h1, DEC_6  = 4'h2, DEC_8  = 4'h3,
    DEC_9   = 4'h4, DEC_10 = 4'h5, DEC_12 = 4'h6, DEC_16 = 4'h7,
    DEC_18  = 4'h8, DEC_20 = 4'h9, DEC_24 = 4'ha, DEC_32 = 4'hb
  } jtfa_dec_e;

  typedef struct packed {
    logic [RAW_N-1:0][RAW_W-1:0] raw;
    logic [CPX_N-1:0][CPX_W-1:0] ci;
    logic [CPX_N-1:0][CPX_W-1:0] cq;
  } jtfa_chan_s;

  typedef struct packed {
    logic [3:0] f;
    logic [3:0] l;
    logic [3:0] m;
    logic [4:0] s;
    logic [5:0] pll;
    logic [1:0] c0;
    logic [1:0] c1;
    logic [1:0] c2;
    logic [3:0] mask;
  } jtfa_info_s;

  // F, L, M, S, PLL, codes 0..2, active lanes per channel
  localparam jtfa_info_s FMT_TAB [8] = '{
    '{4'h8, 4'h8, 4'h2, 5'h14, 6'h10, 2'h3, 2'h0, 2'h0, 4'hf},
    '{4'h2, 4'h8, 4'h2, 5'h04, 6'h14, 2'h1, 2'h0, 2'h0, 4'hf},
    '{4'h1, 4'h8, 4'h4, 5'h01, 6'h14, 2'h1, 2'h1, 2'h0, 4'hf},
    '{4'h2, 4'h8, 4'h4, 5'h02, 6'h14, 2'h1, 2'h0, 2'h0, 4'hf},
    '{4'h2, 4'h4, 4'h4, 5'h01, 6'h14, 2'h1, 2'h0, 2'h0, 4'h3},
    '{4'h2, 4'h4, 4'h4, 5'h01, 6'h28, 2'h0, 2'h0, 2'h1, 4'h6},
    '{4'h4, 4'h4, 4'h4, 5'h02, 6'h28, 2'h2, 2'h0, 2'h0, 4'h6},
    '{4'h4, 4'h2, 4'h4, 5'h01, 6'h28, 2'h2, 2'h0, 2'h0, 4'h2}
  };

  localparam logic [5:0] PLL_40X = 6'h28;

  // Legal formats per decimation setting, one bit per format
  localparam logic [7:0] DEC_LEGAL [16] = '{
    8'h03, 8'h6c, 8'h6c, 8'h90, 8'h90, 8'h90, 8'h90, 8'h90,
    8'h90, 8'h90, 8'h10, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00
  };

  // Lane rate over sample clock, times 100
  localparam logic [9:0] RATIO_LO [16] = '{
    10'h190, 10'h0fa, 10'h0a7, 10'h0fa, 10'h0de, 10'h0c8, 10'h0a7, 10'h07d,
    10'h06f, 10'h064, 10'h0a7, 10'h000, 10'h000, 10'h000, 10'h000, 10'h000
  };
  localparam logic [9:0] RATIO_HI [16] = '{
    10'h1f4, 10'h1f4, 10'h14d, 10'h1f4, 10'h1bc, 10'h190, 10'h14d, 10'h0fa,
    10'h0de, 10'h0c8, 10'h000, 10'h07d, 10'h000, 10'h000, 10'h000, 10'h000
  };

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_STATUS = 8'h04;
  localparam logic [7:0]  ADDR_LINK   = 8'h08;
  localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
  localparam int CTRL_EN    = 0;
  localparam int CTRL_DEC   = 4;
  localparam int CTRL_FMT   = 8;
  localparam int ST_LEGAL   = 0;
  localparam int ST_BUSY    = 1;
  localparam int ST_L       = 4;
  localparam int ST_M       = 8;
  localparam int ST_F       = 12;
  localparam int ST_S       = 16;
  localparam int LK_RATIO   = 0;
  localparam int LK_PLL     = 12;
  localparam int LK_C0      = 20;
  localparam int LK_C1      = 22;
  localparam int LK_C2      = 24;

endpackage : jtfa_pkg

//--- test/jtfa_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module jtfa_assertions (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       ce,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       frm_valid,
  input wire logic       frm_ready,
  input wire logic       lane_valid,
  input wire logic       frame_start,
  input wire logic [3:0] lane_active,
  input wire logic [7:0] chan_a_lane_0,
  input wire logic [1:0] format_select_0,
  input wire logic [1:0] format_select_1,
  input wire logic [1:0] format_select_2
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  wire logic [5:0] codes = {format_select_2, format_select_1, format_select_0};
  sequence s_take;
    ce && frm_valid && frm_ready;
  endsequence
  sequence s_setup;
    psel && !penable && ce;
  endsequence
  property p_first;
    s_take |=> frame_start && lane_valid;
  endproperty
  a_first: assert property (p_first) else $error("frame not started after take");
  property p_cause;
    frame_start && $past(ce) |-> $past(frm_valid && frm_ready);
  endproperty
  a_cause: assert property (p_cause) else $error("frame start without take");
  property p_ce_hold;
    !ce |-> !frm_ready && !pready;
  endproperty
  a_ce_hold: assert property (p_ce_hold) else $error("ready while clock enable low");
  property p_freeze;
    !ce |=> $stable(chan_a_lane_0) && $stable(lane_valid) && $stable(frame_start);
  endproperty
  a_freeze: assert property (p_freeze) else $error("lane moved while frozen");
  property p_err;
    pslverr |-> pready && psel && penable;
  endproperty
  a_err: assert property (p_err) else $error("error outside access phase");
  property p_zero_wait;
    s_setup ##1 (psel && penable && ce) |-> pready;
  endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("bus access not answered");
  property p_mask;
    lane_valid |-> lane_active[1] && (format_select_2 != 2'h1 || lane_active == 4'h6);
  endproperty
  a_mask: assert property (p_mask) else $error("lane mask wrong for format");
  property p_idle;
    !lane_valid |-> lane_active == 4'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("lane mask set while idle");
  property p_codes;
    lane_valid |-> codes inside {6'h03, 6'h01, 6'h05, 6'h10, 6'h02};
  endproperty
  a_codes: assert property (p_codes) else $error("format select code illegal");
  property p_mid;
    frame_start && codes != 6'h05 |-> !frm_ready;
  endproperty
  a_mid: assert property (p_mid) else $error("frame taken mid frame");
endmodule : jtfa_assertions
bind jtfa_frame_assembler jtfa_assertions i_jtfa_assertions (.core_clk, .rst_n, .ce, .psel,
  .penable, .pready, .pslverr, .frm_valid, .frm_ready, .lane_valid, .frame_start,
  .lane_active, .chan_a_lane_0, .format_select_0, .format_select_1, .format_select_2);
`default_nettype wire

//--- test/jtfa_link_rx.sv
`timescale 1ns/1ns
`default_nettype none
module jtfa_link_rx (
  input  wire logic            core_clk,
  input  wire logic            rst_n,
  input  wire logic            ce,
  input  wire logic            lane_valid,
  input  wire logic            frame_start,
  input  wire logic [3:0]      f_cfg,
  input  wire logic [7:0][7:0] lanes,
  output logic                 rx_done,
  output logic [7:0][63:0]     rx_word,
  output logic                 rx_err
);
  logic [3:0]       cnt_r;
  logic [3:0]       cnt_nxt;
  logic [7:0][63:0] acc_r;
  logic [7:0][63:0] acc_nxt;
  wire logic        last = ce && lane_valid && cnt_nxt == f_cfg;
  // Octets shift in first octet first, MSB first
  always_comb begin
    cnt_nxt = frame_start ? 4'h1 : cnt_r + 4'h1;
    for (int l = 0; l < 8; l++) acc_nxt[l] = {frame_start ? 56'h0 : acc_r[l][55:0], lanes[l]};
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_r <= '0;
      acc_r <= '0;
      rx_done <= 1'b0;
      rx_word <= '0;
      rx_err <= 1'b0;
    end else begin
      rx_done <= last;
      if (ce && lane_valid) begin
        cnt_r <= last ? 4'h0 : cnt_nxt;
        acc_r <= acc_nxt;
        if (frame_start != (cnt_r == 4'h0)) rx_err <= 1'b1;
        if (last) for (int l = 0; l < 8; l++) rx_word[l] <= acc_nxt[l] << (8 * (8 - f_cfg));
      end
    end
  end
endmodule : jtfa_link_rx
`default_nettype wire

//--- test/jtfa_frame_assembler_test.sv
`timescale 1ns/1ns
`default_nettype none
module jtfa_frame_assembler_test;
  logic core_clk = 0, rst_n = 0, ce = 0, rc = 0, psel = 0, penable = 0, pwrite = 0;
  logic frm_valid = 0, rx_done, rx_err, perr;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, rd;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, frm_ready, lane_valid, frame_start;
  wire logic [7:0][7:0] ln;
  wire logic [3:0] lane_active;
  wire logic [1:0] fs0, fs1, fs2;
  logic [3:0] fcfg = 4'h1;
  logic [7:0][63:0] rx_word;
  jtfa_pkg::jtfa_chan_s ca = '0, cb = '0, qa[$], qb[$];
  logic [2:0] cur = '0, qf[$];
  int err_count = 0, num_checks = 0, seed = 32'h5b1c5b2b, d, f;
  int lo[12] = '{400, 250, 167, 250, 222, 200, 167, 125, 111, 100, 167, 0};
  int hi[12] = '{500, 500, 333, 500, 444, 400, 333, 250, 222, 200, 0, 125};
  int ff[8] = '{8, 2, 1, 2, 2, 2, 4, 4}, ll[8] = '{8, 8, 8, 8, 4, 4, 4, 2};
  int mm[8] = '{2, 2, 4, 4, 4, 4, 4, 4}, ss[8] = '{20, 4, 1, 2, 1, 1, 2, 1};
  int cd[8] = '{3, 1, 5, 1, 1, 16, 2, 2}, pl[8] = '{16, 20, 20, 20, 20, 40, 40, 40};
  int dd[8] = '{0, 0, 1, 2, 10, 2, 1, 11}, mk[8] = '{15, 15, 15, 15, 3, 6, 6, 2};
  jtfa_frame_assembler i_jtfa_frame_assembler (.core_clk, .rst_n, .ce, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .frm_valid, .frm_ready,
    .chan_a_in(ca), .chan_b_in(cb), .chan_a_lane_0(ln[0]), .chan_a_lane_1(ln[1]),
    .chan_a_lane_2(ln[2]), .chan_a_lane_3(ln[3]), .chan_b_lane_0(ln[4]),
    .chan_b_lane_1(ln[5]), .chan_b_lane_2(ln[6]), .chan_b_lane_3(ln[7]), .lane_valid,
    .frame_start, .lane_active, .format_select_0(fs0), .format_select_1(fs1),
    .format_select_2(fs2));
  jtfa_link_rx i_jtfa_link_rx (.core_clk, .rst_n, .ce, .lane_valid, .frame_start,
    .f_cfg(fcfg), .lanes(ln), .rx_done, .rx_word, .rx_err);
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) if (rc) ce <= ($random(seed) & 7) != 0;
  task automatic test_done();
    if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    perr = pslverr;
    psel <= 0;
    penable <= 0;
    if (n >= 50) begin
      err_count++;
      test_done();
    end
  endtask : apb
  function automatic jtfa_pkg::jtfa_chan_s rnd();
    logic [351:0] t;
    repeat (11) t = {t[319:0], $random(seed)};
    return t[343:0];
  endfunction : rnd
  task automatic send();
    int n;
    n = 0;
    ca <= rnd();
    cb <= rnd();
    frm_valid <= 1;
    do begin
      @(posedge core_clk);
      n++;
    end while ((ce & frm_valid & frm_ready) !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
      test_done();
    end
  endtask : send
  function automatic logic legal(int d, int f);
    case (d)
      0: return f < 2;
      1, 2: return f inside {2, 3, 5, 6};
      10: return f == 4;
      11: return f == 7;
      default: return d < 10 && (f == 4 || f == 7);
    endcase
  endfunction : legal
  function automatic logic [63:0] lane_word(logic [2:0] fm, jtfa_pkg::jtfa_chan_s c, int k);
    logic [63:0] w;
    logic [15:0] v;
    w = '0;
    v = k < 2 ? c.ci[0] : c.cq[0];
    case (fm)
      0: for (int j = 0; j < 5; j++) w[63-12*j -: 12] = c.raw[5*k+j][13:2];
      1: w = {c.raw[k], 2'b00, 48'h0};
      2: w = {(k % 2 ? v[7:0] : v[15:8]), 56'h0};
      3: w = {(k < 2 ? c.ci[k%2] : c.cq[k%2]), 48'h0};
      4: w = k == 0 ? {c.ci[0], 48'h0} : k == 1 ? {c.cq[0], 48'h0} : 64'h0;
      5: w = k == 1 ? {c.ci[0], 48'h0} : k == 2 ? {c.cq[0], 48'h0} : 64'h0;
      6: w = k == 1 ? {c.ci[0], c.ci[1], 32'h0} : k == 2 ? {c.cq[0], c.cq[1], 32'h0} : 64'h0;
      default: w = k == 1 ? {c.ci[0], c.cq[0], 32'h0} : 64'h0;
    endcase
    return w;
  endfunction : lane_word
  always @(posedge core_clk) begin
    if (rx_done === 1'b1) begin
      for (int k = 0; k < 8; k++)
        chk("lane", lane_word(qf[0], k < 4 ? qa[0] : qb[0], k % 4), rx_word[k]);
      chk("fsel", cd[qf[0]], {fs2, fs1, fs0});
      chk("rx_err", 0, rx_err);
      qa.delete(0);
      qb.delete(0);
      qf.delete(0);
    end
    if (lane_valid === 1'b1) chk("lane_active", mk[cur], lane_active);
    if ((ce & frm_valid & frm_ready) === 1'b1) begin
      qa.push_back(ca);
      qb.push_back(cb);
      qf.push_back(cur);
    end
  end
  initial begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1;
    ce <= 1;
    apb(0, 8'h0c, '0);
    chk("unmapped", 1, perr);
    apb(0, 8'h00, '0);
    chk("ctrl_rst", 0, rd);
    apb(1, 8'h00, 32'h5a5a_a5a5);
    apb(0, 8'h00, '0);
    chk("ctrl", 32'h5a5a_a5a5, rd);
    for (d = 0; d < 12; d++)
      for (f = 0; f < 8; f++) begin
        apb(1, 8'h00, {21'h0, f[2:0], d[3:0], 4'h1});
        apb(0, 8'h04, '0);
        chk("legal", legal(d, f), rd[0]);
        if (legal(d, f)) begin
          chk("lmfs", {ss[f][4:0], ff[f][3:0], mm[f][3:0], ll[f][3:0]}, rd[20:4]);
          apb(0, 8'h08, '0);
          chk("link", {cd[f][5:0], pl[f][5:0], ((f == 1 || f > 4) ? hi[d][9:0] : lo[d][9:0])},
              {rd[25:20], rd[17:12], rd[9:0]});
        end
      end
    apb(1, 8'h00, {21'h0, 3'h0, 4'hb, 4'h1});
    frm_valid <= 1;
    repeat (2) @(posedge core_clk);
    chk("refused", 0, frm_ready);
    frm_valid <= 0;
    rc <= 1;
    for (f = 0; f < 8; f++) begin
      cur = f[2:0];
      fcfg <= ff[f][3:0];
      apb(1, 8'h00, {21'h0, f[2:0], dd[f][3:0], 4'h1});
      repeat (6) send();
      frm_valid <= 0;
      for (int n = 0; qf.size() > 0; n++) begin
        if (n > 200) begin
          err_count++;
          test_done();
        end
        @(posedge core_clk);
      end
    end
    test_done();
  end
endmodule : jtfa_frame_assembler_test
`default_nettype wire
